// *** bench/mitc_core_checker.sv ***
// Purpose: port-level checks of the instruction timing core
// Assumes: program in memory never holds a jump or logic word in a discarded slot
// Notes:   opcode read from progData at the fetch edge
`timescale 1ns/10ps
module mitc_core_checker (
  input wire        sys_clk,
  input wire        rst,
  input wire [11:0] progAddr,
  input wire [15:0] progData,
  input wire [7:0]  dataAddr,
  input wire        dataWrEn,
  input wire [7:0]  acc,
  input wire        zeroFlag,
  input wire        halted,
  input wire [1:0]  phase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_cyc;
    !rst && phase == 2'd0 |=> phase == 2'd1 ##1 phase == 2'd2 ##1 phase == 2'd3 ##1 phase == 2'd0;
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle not four clocks");
  property p_pa; (phase == 2'd0 || phase == 2'd2) |=> $stable(progAddr); endproperty
  a_pa: assert property (p_pa) else $error("program address moved mid cycle");
  property p_da; phase != 2'd3 |=> $stable(dataAddr); endproperty
  a_da: assert property (p_da) else $error("data address moved mid cycle");
  property p_we; dataWrEn |-> phase == 2'd3 ##1 !dataWrEn; endproperty
  a_we: assert property (p_we) else $error("write strobe misplaced");
  property p_pc_low; dataWrEn |-> dataAddr != 8'h00; endproperty
  a_pc_low: assert property (p_pc_low) else $error("counter low write reached memory");
  property p_halt; halted |-> !dataWrEn; endproperty
  a_halt: assert property (p_halt) else $error("write while powered down");
  property p_branch;
    phase == 2'd3 && !halted && progData[15:12] inside {4'h1, 4'h2} |-> ##5 progAddr == $past(progData[11:0], 5);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target not fetched");
  property p_zero;
    phase == 2'd3 && !halted && progData[15:12] == 4'h5 && progData[11:8] inside {4'h4, 4'h5, 4'h6}
      |-> ##4 zeroFlag == (acc == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong after logic");
endmodule // mitc_core_checker

// *** bench/mitc_core_tb.sv ***
// Purpose: self-checking bench for the instruction timing core
// Assumes: every data write is a result noted in order of execution
// Notes:   ends on halt and wake
`timescale 1ns/10ps
module mitc_core_tb;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        wakeUp = 1'h0;
  wire  [11:0] progAddr;
  wire  [15:0] progData;
  wire  [7:0]  dataAddr, dataRdData, dataWrData, acc;
  wire         dataWrEn, carryFlag, zeroFlag, halted;
  wire  [1:0]  phase;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          i;
  logic [17:0] expQ[$];
  logic [17:0] e;
  logic [8:0]  sum;
  logic [7:0]  a, b, c, d, nb;
  logic [15:0] tw;

  always #4 sys_clk = ~sys_clk;

  mitc_core DUT (.sys_clk(sys_clk), .rst(rst), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataRdData(dataRdData), .dataWrData(dataWrData), .dataWrEn(dataWrEn), .wakeUp(wakeUp), .acc(acc),
    .carryFlag(carryFlag), .zeroFlag(zeroFlag), .halted(halted), .phase(phase));
  mitc_mem_model mem (.sys_clk(sys_clk), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataRdData(dataRdData), .dataWrData(dataWrData), .dataWrEn(dataWrEn));

  task cmp(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task put(input logic [11:0] ad, input logic [15:0] w);
    mem.rom[ad] = w;
  endtask
  task note(input logic zc, input logic z, input logic [7:0] ad, input logic [7:0] v);
    expQ.push_back({zc, z, ad, v});
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // takes the oldest note whenever a write appears
  always @(posedge sys_clk) begin
    if (!rst && dataWrEn === 1'h1) begin
      if (expQ.size() == 0) cmp("extra write", 18'h0, {2'h0, dataAddr, dataWrData});
      else begin
        e = expQ.pop_front();
        cmp("write", {e[17], e[17] & e[16], e[15:0]}, {e[17], e[17] & zeroFlag, dataAddr, dataWrData});
      end
    end
  end

  initial begin
    #40000;
    error_cnt++;
    end_sim;
  end

  initial begin
    void'($urandom(92));
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    d = 8'($urandom);
    tw = 16'($urandom) & 16'h0fff;
    sum = {1'h0, a} + {1'h0, b};
    nb = (sum[7:0] >= c) ? 8'h01 : 8'h00;
    foreach (mem.rom[k]) mem.rom[k] = 16'h0000;
    mem.ram[8'h20] = 8'h00;
    mem.ram[8'h21] = 8'h00;
    mem.ram[8'h22] = 8'h00;
    mem.ram[8'h30] = d;
    put(12'h000, {8'h57, a});
    put(12'h001, {8'h50, b});
    put(12'h002, 16'h4710); note(1'h0, 1'h0, 8'h10, sum[7:0]);
    put(12'h003, 16'h7620); note(1'h0, 1'h0, 8'h20, {7'h0, sum[8]});
    put(12'h004, {8'h52, c});
    put(12'h005, 16'h4711); note(1'h0, 1'h0, 8'h11, sum[7:0] - c);
    put(12'h006, 16'h7621); note(1'h0, 1'h0, 8'h21, nb);
    put(12'h007, 16'h7021); note(1'h0, 1'h0, 8'h21, nb + 8'h01);
    put(12'h008, 16'h6121);
    put(12'h009, 16'h4712); note(1'h0, 1'h0, 8'h12, nb);
    put(12'h00a, 16'h8330); note(1'h0, 1'h0, 8'h30, d | 8'h08);
    put(12'h00b, 16'h9530); note(1'h0, 1'h0, 8'h30, (d | 8'h08) & 8'hdf);
    put(12'h00c, 16'hc022);
    put(12'h00d, 16'h4713);
    put(12'h00e, 16'hc122);
    put(12'h00f, 16'h4714); note(1'h0, 1'h0, 8'h14, nb);
    put(12'h010, 16'h2080);
    put(12'h080, 16'h4715); note(1'h0, 1'h0, 8'h15, nb);
    put(12'h081, 16'h0100);
    put(12'h011, 16'h4716); note(1'h0, 1'h0, 8'h16, nb);
    put(12'h012, 16'h1040);
    put(12'h013, 16'h4717);
    put(12'h040, 16'h5790);
    put(12'h090, tw);
    put(12'h041, 16'hd000);
    put(12'h042, 16'h4718); note(1'h0, 1'h0, 8'h18, tw[7:0]);
    put(12'h043, 16'h5760);
    put(12'h044, 16'h4700);
    put(12'h045, 16'h4719);
    put(12'h060, 16'h575a);
    put(12'h061, 16'h54a5);
    put(12'h062, 16'h471b); note(1'h1, 1'h1, 8'h1b, 8'h00);
    put(12'h063, 16'h55a5);
    put(12'h064, 16'h471c); note(1'h1, 1'h0, 8'h1c, 8'ha5);
    put(12'h065, 16'h0200);
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    for (i = 0; i < 2000 && halted !== 1'h1; i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    cmp("halted", 18'h1, {17'h0, halted});
    cmp("pending", 18'h0, 18'(expQ.size()));
    wakeUp <= 1'h1;
    repeat (16) @(posedge sys_clk);
    cmp("woken", 18'h0, {17'h0, halted});
    end_sim;
  end
endmodule // mitc_core_tb

bind mitc_core mitc_core_checker u_chk (.sys_clk(sys_clk), .rst(rst), .progAddr(progAddr), .progData(progData),
  .dataAddr(dataAddr), .dataWrEn(dataWrEn), .acc(acc), .zeroFlag(zeroFlag), .halted(halted), .phase(phase));

// *** bench/mitc_mem_model.sv ***
// Purpose: synchronous program and data memory facing the core
// Assumes: one clock read latency on both memories
// Notes:   contents loaded by the bench before reset release
`timescale 1ns/10ps
module mitc_mem_model (
  input  wire         sys_clk,
  input  wire  [11:0] progAddr,
  output logic [15:0] progData = 16'h0000,
  input  wire  [7:0]  dataAddr,
  output logic [7:0]  dataRdData = 8'h00,
  input  wire  [7:0]  dataWrData,
  input  wire         dataWrEn
);
  logic [15:0] rom [0:4095];
  logic [7:0]  ram [0:255];

  always @(posedge sys_clk) begin
    progData <= rom[progAddr];
    dataRdData <= ram[dataAddr];
    if (dataWrEn) begin
      ram[dataAddr] <= dataWrData;
    end
  end
endmodule // mitc_mem_model

// *** hdl/mitc_core.v ***
// Purpose: 8-bit core executing one instruction per four-clock cycle
// Assumes: program and data memories read synchronously, one clock latency
// Notes:   addresses change only at the last phase edge of a cycle, except progAddr at the table phase edge of a table read
//          pc runs one word ahead of the instruction in execution
`timescale 1ns/10ps
`include "mitc_core_map.vh"

module mitc_core (
  input  wire        sys_clk,
  input  wire        rst,
  output reg  [11:0] progAddr,
  input  wire [15:0] progData,
  output reg  [7:0]  dataAddr,
  input  wire [7:0]  dataRdData,
  output reg  [7:0]  dataWrData,
  output reg         dataWrEn,
  input  wire        wakeUp,
  output reg  [7:0]  acc,
  output reg         carryFlag,
  output reg         zeroFlag,
  output reg         halted,
  output reg  [1:0]  phase
);

  reg  [15:0] ir;
  reg  [11:0] pc;
  reg  [11:0] stack [0:7];
  reg  [2:0]  sp;
  reg         tablePending;
  reg         flushNext;
  reg         wakeMeta;
  reg         wakeSync;

  wire [3:0]  op      = ir[15:12];
  wire [3:0]  sub     = ir[11:8];
  wire [7:0]  operand = ir[7:0];
  wire        isPcLow = (operand == `MITC_PC_LOW_ADDR);
  // the counter low byte reads back as the next fetch address
  wire [7:0]  memVal  = isPcLow ? pc[7:0] : dataRdData;
  wire [7:0]  bitMask = 8'h01 << sub[2:0];

  // decode results of the instruction in the execute slot
  reg  [8:0]  sum;
  reg  [7:0]  bIn;
  reg  [7:0]  unRes;
  reg         unCarry;
  reg  [7:0]  next_acc;
  reg         next_carry;
  reg         next_zero;
  reg         wbEn;
  reg  [7:0]  wbVal;
  reg         jump;
  reg  [11:0] jumpTarget;
  reg         skip;
  reg         push;
  reg         pop;
  reg         tableStart;
  reg         haltReq;

  // alu for two-operand operations
  always @* begin
    bIn = (op == `MITC_OP_ALU_IMM) ? operand : memVal;
    case (sub[2:0])
      `MITC_ALU_ADD: sum = {1'b0, acc} + {1'b0, bIn};
      `MITC_ALU_ADC: sum = {1'b0, acc} + {1'b0, bIn} + {8'h00, carryFlag};
      `MITC_ALU_SUB: sum = {1'b0, acc} - {1'b0, bIn};
      `MITC_ALU_SBC: sum = {1'b0, acc} - {1'b0, bIn} - {8'h00, ~carryFlag};
      `MITC_ALU_AND: sum = {1'b0, acc & bIn};
      `MITC_ALU_OR:  sum = {1'b0, acc | bIn};
      `MITC_ALU_XOR: sum = {1'b0, acc ^ bIn};
      default:       sum = {1'b0, (op == `MITC_OP_ALU_MEM) ? acc : bIn};
    endcase
  end

  // single operand operations on a data memory byte
  always @* begin
    unCarry = carryFlag;
    case (sub[2:0])
      `MITC_UN_INC: unRes = memVal + 8'h01;
      `MITC_UN_DECR:   unRes = memVal - 8'h01;
      `MITC_UN_COMPL:  unRes = ~memVal;
      `MITC_UN_ROT_R:  unRes = {memVal[0], memVal[7:1]};
      `MITC_UN_ROT_L:  unRes = {memVal[6:0], memVal[7]};
      // through-carry variants trade the outgoing bit for the carry
      `MITC_UN_ROT_RC: begin
        unRes   = {carryFlag, memVal[7:1]};
        unCarry = memVal[0];
      end
      `MITC_UN_ROT_LC: begin
        unRes   = {memVal[6:0], carryFlag};
        unCarry = memVal[7];
      end
      default:      unRes = memVal;
    endcase
  end

  // decode of the instruction in the execute slot
  always @* begin
    next_acc   = acc;
    next_carry = carryFlag;
    next_zero  = zeroFlag;
    wbEn       = 1'b0;
    wbVal      = 8'h00;
    jump       = 1'b0;
    jumpTarget = ir[11:0];
    skip       = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    tableStart = 1'b0;
    haltReq    = 1'b0;
    case (op)
      `MITC_OP_MISC: begin
        if (sub == `MITC_MISC_SUBRTN || sub == `MITC_MISC_INTRTN) begin
          pop        = 1'b1;
          jump       = 1'b1;
          jumpTarget = stack[sp - 3'd1];
        end
        if (sub == `MITC_MISC_HALT)
          haltReq = 1'b1;
      end
      `MITC_OP_JUMP: jump = 1'b1;
      `MITC_OP_CALL: begin
        jump = 1'b1;
        push = 1'b1;
      end
      `MITC_OP_ALU_ACC, `MITC_OP_ALU_IMM, `MITC_OP_ALU_MEM: begin
        if (op == `MITC_OP_ALU_MEM) begin
          wbEn  = 1'b1;
          wbVal = sum[7:0];
        end else
          next_acc = sum[7:0];
        if (sub[2:0] != `MITC_ALU_MOV)
          next_zero = (sum[7:0] == 8'h00);
        // after a subtraction, carry set means no borrow
        if (sub[2:0] == `MITC_ALU_ADD || sub[2:0] == `MITC_ALU_ADC)
          next_carry = sum[8];
        else if (sub[2:0] == `MITC_ALU_SUB || sub[2:0] == `MITC_ALU_SBC)
          next_carry = ~sum[8];
      end
      `MITC_OP_UN_ACC, `MITC_OP_UN_MEM: begin
        if (op == `MITC_OP_UN_MEM) begin
          wbEn  = 1'b1;
          wbVal = unRes;
        end else
          next_acc = unRes;
        if (sub[2:0] <= `MITC_UN_COMPL)
          next_zero = (unRes == 8'h00);
        next_carry = unCarry;
      end
      `MITC_OP_BIT_SET: begin
        wbEn  = 1'b1;
        wbVal = memVal | bitMask;
      end
      `MITC_OP_BIT_CLR: begin
        wbEn  = 1'b1;
        wbVal = memVal & ~bitMask;
      end
      `MITC_OP_SKIP_BZ:  skip = ((memVal & bitMask) == 8'h00);
      `MITC_OP_SKIP_BNZ: skip = ((memVal & bitMask) != 8'h00);
      `MITC_OP_SKIP_BYTE: begin
        case (sub[1:0])
          `MITC_SK_ZERO:  skip = (memVal == 8'h00);
          `MITC_SK_NZERO: skip = (memVal != 8'h00);
          // counting skips write back and test the new value
          `MITC_SK_INC: begin
            wbEn  = 1'b1;
            wbVal = memVal + 8'h01;
            skip  = (wbVal == 8'h00);
          end
          default: begin
            wbEn  = 1'b1;
            wbVal = memVal - 8'h01;
            skip  = (wbVal == 8'h00);
          end
        endcase
      end
      `MITC_OP_TABLE: tableStart = 1'b1;
      default: ;
    endcase
    // a write to the counter low byte becomes a jump
    if (wbEn && isPcLow) begin
      jump       = 1'b1;
      jumpTarget = {pc[11:8], wbVal};
    end
  end

  // wake pin synchroniser
  always @(posedge sys_clk) begin
    if (rst) begin
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
    end else begin
      wakeMeta <= wakeUp;
      wakeSync <= wakeMeta;
    end
  end

  // free-running position inside the instruction cycle
  always @(posedge sys_clk) begin
    if (rst)
      phase <= 2'd0;
    else
      phase <= phase + 2'd1;
  end

  // write strobe: raised at commit, dropped at the last phase
  always @(posedge sys_clk) begin
    if (rst) begin
      dataWrEn   <= 1'b0;
      dataWrData <= 8'h00;
    end else if (!halted && phase == `MITC_PH_COMMIT && wbEn && !isPcLow) begin
      dataWrEn   <= 1'b1;
      dataWrData <= wbVal;
    end else if (phase == `MITC_PH_LAST)
      dataWrEn <= 1'b0;
  end

  // return stack kept out of the reset branch so it maps to plain storage
  always @(posedge sys_clk) begin
    if (!rst && !halted && phase == `MITC_PH_COMMIT && push)
      stack[sp] <= pc;
  end

  // fetch, commit and table-read sequencing
  always @(posedge sys_clk) begin
    if (rst) begin
      // first cycle after reset is a bubble running a no-op
      pc           <= `MITC_RST_PC;
      progAddr     <= `MITC_RST_PC;
      ir           <= `MITC_NOP_WORD;
      dataAddr     <= `MITC_PC_LOW_ADDR;
      acc          <= `MITC_RST_ACC;
      carryFlag    <= 1'b0;
      zeroFlag     <= 1'b0;
      halted       <= 1'b0;
      sp           <= 3'd0;
      tablePending <= 1'b0;
      flushNext    <= 1'b0;
    end else begin
      if (!halted && phase == `MITC_PH_TABLE && tablePending) begin
        // table word arrives in the bubble; its upper byte is unused
        acc          <= progData[7:0];
        progAddr     <= pc;
        tablePending <= 1'b0;
      end
      if (!halted && phase == `MITC_PH_COMMIT) begin
        acc       <= next_acc;
        carryFlag <= next_carry;
        zeroFlag  <= next_zero;
        halted    <= haltReq;
        // pc already points past the call, so the stack takes it as it is
        if (push)
          sp <= sp + 3'd1;
        // circular stack: an overflow overwrites the oldest entry
        if (pop)
          sp <= sp - 3'd1;
        // a table read holds pc so the bubble refetches the next word
        if (jump)
          pc <= jumpTarget;
        else if (!tableStart)
          pc <= pc + 12'h001;
        // the word fetched behind a flow change is dropped
        flushNext    <= jump | skip;
        tablePending <= tableStart;
      end
      if (phase == `MITC_PH_LAST) begin
        // a woken core runs the word fetched behind the halt, not the halt again
        if (halted && wakeSync)
          halted <= 1'b0;
        if (!halted || wakeSync) begin
          if (flushNext || tablePending) begin
            ir       <= `MITC_NOP_WORD;
            dataAddr <= `MITC_PC_LOW_ADDR;
            progAddr <= tablePending ? {ir[11:8], acc} : pc;
          end else begin
            ir       <= progData;
            dataAddr <= progData[7:0];
            progAddr <= pc;
          end
        end
      end
    end
  end

endmodule // mitc_core

// *** hdl/mitc_core_map.vh ***
// Purpose: constants of the instruction timing core
// Assumes: 16-bit instruction word, 12-bit program address, 8-bit data
// Notes:   opcode field is instr[15:12], sub field instr[11:8], operand instr[7:0]
`ifndef MITC_CORE_MAP_VH
`define MITC_CORE_MAP_VH

// instruction cycle length in system clocks
`define MITC_PHASES       3'd4
`define MITC_PH_LAST      2'd3
`define MITC_PH_TABLE     2'd1
`define MITC_PH_COMMIT    2'd2

// data memory location that aliases the program counter low byte
`define MITC_PC_LOW_ADDR  8'h00

// reset values
`define MITC_RST_PC       12'h000
`define MITC_RST_ACC      8'h00
`define MITC_NOP_WORD     16'h0000

// opcode classes
`define MITC_OP_MISC      4'h0
`define MITC_OP_JUMP      4'h1
`define MITC_OP_CALL      4'h2
`define MITC_OP_ALU_ACC   4'h3
`define MITC_OP_ALU_MEM   4'h4
`define MITC_OP_ALU_IMM   4'h5
`define MITC_OP_UN_ACC    4'h6
`define MITC_OP_UN_MEM    4'h7
`define MITC_OP_BIT_SET   4'h8
`define MITC_OP_BIT_CLR   4'h9
`define MITC_OP_SKIP_BZ   4'ha
`define MITC_OP_SKIP_BNZ  4'hb
`define MITC_OP_SKIP_BYTE 4'hc
`define MITC_OP_TABLE     4'hd

// misc sub codes
`define MITC_MISC_NOP     4'h0
`define MITC_MISC_SUBRTN  4'h1
`define MITC_MISC_HALT    4'h2
`define MITC_MISC_INTRTN  4'h3

// alu sub codes
`define MITC_ALU_ADD      3'h0
`define MITC_ALU_ADC      3'h1
`define MITC_ALU_SUB      3'h2
`define MITC_ALU_SBC      3'h3
`define MITC_ALU_AND      3'h4
`define MITC_ALU_OR       3'h5
`define MITC_ALU_XOR      3'h6
`define MITC_ALU_MOV      3'h7

// unary sub codes
`define MITC_UN_INC       3'h0
`define MITC_UN_DECR      3'h1
`define MITC_UN_COMPL     3'h2
`define MITC_UN_ROT_R     3'h3
`define MITC_UN_ROT_L     3'h4
`define MITC_UN_ROT_RC    3'h5
`define MITC_UN_ROT_LC    3'h6

// byte skip sub codes
`define MITC_SK_ZERO      2'h0
`define MITC_SK_NZERO     2'h1
`define MITC_SK_INC       2'h2
`define MITC_SK_DECR      2'h3

`endif
